// ### core/interrupt_vector_status_control.sv
// control/status and vector base registers of the interrupt controller
// assumes arbitration, the core and the debug unit share sys_clk
module interrupt_vector_status_control #(
   parameter logic [15:0] VBA_RESET = intc_vsc_pkg::VBA_RST_FULL
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic ce,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // winning request from arbitration
   input wire logic req_valid,
   input wire logic req_maskable,
   input wire logic [1:0] req_level,
   input wire logic [intc_vsc_pkg::LOWVEC_W-1:0] req_vector_low,
   // core side
   input wire logic core_isr_entry,
   output logic irq_to_core,
   output logic [intc_vsc_pkg::VADDR_W-1:0] vector_addr,
   // debug sources
   input wire logic [4:0] dbg_irq_src,
   output logic [4:0] dbg_irq_req
);
   import intc_vsc_pkg::*;

   logic [15:0] vba_r;
   logic global_mask_disable_r;
   logic [4:0] dbg_en_r;
   nest_code_t nesting_priority_level_r;
   logic [LOWVEC_W-1:0] last_vector_low_bits_r;
   logic [15:0] icsr_view;
   logic wr_icsr;
   logic wr_vba;

   // nesting threshold for a request of the given level
   function automatic nest_code_t nest_for(input logic [1:0] lvl);
      case (lvl)
         2'h0: nest_for = NEST_L1_UP;
         2'h1: nest_for = NEST_L2_UP;
         default: nest_for = NEST_L3_ONLY;
      endcase
   endfunction : nest_for

   // ****************************************************************
   // register writes
   // ****************************************************************
   assign wr_icsr = ce && reg_wr && (reg_addr == OFS_CTRL_STATUS);
   assign wr_vba = ce && reg_wr && (reg_addr == OFS_VECTOR_BASE);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         global_mask_disable_r <= CTRL_RST[BIT_GLOBAL_DIS];
         dbg_en_r <= CTRL_RST[DBG_EN_HI:DBG_EN_LO];
      end else if (wr_icsr) begin
         global_mask_disable_r <= reg_wdata[BIT_GLOBAL_DIS];
         dbg_en_r <= reg_wdata[DBG_EN_HI:DBG_EN_LO];
      end
   end

   // vector base, top two bits held at zero
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         vba_r <= {2'b00, VBA_RESET[BASE_W-1:0]};
      end else if (wr_vba) begin
         vba_r <= {2'b00, reg_wdata[BASE_W-1:0]};
      end
   end

   // ****************************************************************
   // service routine entry capture
   // ****************************************************************
   // snapshot on core entering a new routine
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         nesting_priority_level_r <= nest_code_t'(NEST_RST);
         last_vector_low_bits_r <= LASTVEC_RST;
      end else if (ce && core_isr_entry) begin
         nesting_priority_level_r <= nest_for(req_level);
         last_vector_low_bits_r <= req_vector_low;
      end
   end

   // ****************************************************************
   // core request, vector address, debug gating
   // ****************************************************************
   // maskable requests held back while disabled
   assign irq_to_core = req_valid && !(req_maskable && global_mask_disable_r);

   // base over low bits; reset shows the base with zero low bits
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         vector_addr <= {VBA_RESET[BASE_W-1:0], 7'h00};
      end else if (ce) begin
         vector_addr <= {vba_r[BASE_W-1:0], req_vector_low};
      end
   end

   // debug sources passed only when enabled
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dbg_irq_req <= 5'h00;
      end else if (ce) begin
         dbg_irq_req <= dbg_irq_src & dbg_en_r;
      end
   end

   // ****************************************************************
   // register reads
   // ****************************************************************
   // live status bit beside stored fields
   assign icsr_view = {irq_to_core, nesting_priority_level_r, last_vector_low_bits_r,
                       global_mask_disable_r, dbg_en_r};

   // read data registered; unmapped offsets return zero
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (ce && reg_rd) begin
         if (reg_addr == OFS_CTRL_STATUS) begin
            reg_rdata <= icsr_view;
         end else if (reg_addr == OFS_VECTOR_BASE) begin
            reg_rdata <= vba_r;
         end else begin
            reg_rdata <= 16'h0000;
         end
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence s_entry;
      ce && core_isr_entry;
   endsequence

   sequence s_read_icsr;
      ce && reg_rd && (reg_addr == OFS_CTRL_STATUS);
   endsequence

   a_status_live_bit: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_read_icsr |=> reg_rdata[BIT_IRQ_ACTIVE] == $past(irq_to_core))
      else $error("status bit does not match core request");

   a_mask_suppress: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (global_mask_disable_r && req_maskable) |-> !irq_to_core)
      else $error("maskable request passed while disabled");

   a_nest_update: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_entry |=> nesting_priority_level_r == (($past(req_level) == 2'h0) ? NEST_L1_UP
         : ($past(req_level) == 2'h1) ? NEST_L2_UP : NEST_L3_ONLY))
      else $error("nesting level wrong after routine entry");

   a_nest_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !(ce && core_isr_entry) |=> $stable(nesting_priority_level_r))
      else $error("nesting level moved without routine entry");

   a_lastvec_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_entry ##1 (!(ce && core_isr_entry))[*2] |->
         last_vector_low_bits_r == $past(req_vector_low, 2))
      else $error("last vector bits not held from entry");

   a_vaddr_compose: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ce |=> vector_addr == {$past(vba_r[BASE_W-1:0]), $past(req_vector_low)})
      else $error("vector address not base over low bits");

   a_vba_reserved: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_vba |=> (vba_r[15:14] == 2'b00) && (vba_r[13:0] == $past(reg_wdata[13:0])))
      else $error("vector base write stored wrong");

   a_dbg_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ce |=> dbg_irq_req == ($past(dbg_irq_src) & $past(dbg_en_r)))
      else $error("debug request not gated by enable");

   a_reset_defaults: assert property (@(posedge sys_clk)
      $fell(sys_rst) |-> (vba_r == {2'b00, VBA_RESET[13:0]}) && !global_mask_disable_r
         && (dbg_en_r == 5'h00) && (nesting_priority_level_r == NEST_ANY)
         && (last_vector_low_bits_r == LASTVEC_RST))
      else $error("registers not at defaults after reset");

   sequence s_write_ctrl;
      ce && reg_wr && (reg_addr == OFS_CTRL_STATUS);
   endsequence

   a_ctrl_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_write_ctrl |=> (global_mask_disable_r == $past(reg_wdata[BIT_GLOBAL_DIS]))
         && (dbg_en_r == $past(reg_wdata[DBG_EN_HI:DBG_EN_LO])))
      else $error("control write not stored");

   a_ctrl_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !(ce && reg_wr && (reg_addr == OFS_CTRL_STATUS)) |=>
         $stable(global_mask_disable_r) && $stable(dbg_en_r))
      else $error("control bits moved without a write");

   a_vba_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !wr_vba |=> $stable(vba_r))
      else $error("vector base moved without a write");

   a_lastvec_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !(ce && core_isr_entry) |=> $stable(last_vector_low_bits_r))
      else $error("last vector bits moved without routine entry");

   a_read_unmapped: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (ce && reg_rd && (reg_addr != OFS_CTRL_STATUS) && (reg_addr != OFS_VECTOR_BASE)) |=>
         (reg_rdata == 16'h0000))
      else $error("unmapped offset read not zero");

   a_read_vba: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (ce && reg_rd && (reg_addr == OFS_VECTOR_BASE)) |=>
         (reg_rdata[15:14] == 2'h0) && (reg_rdata[13:0] == $past(vba_r[13:0])))
      else $error("vector base read wrong");

   a_rdata_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !(ce && reg_rd) |=> $stable(reg_rdata))
      else $error("read data moved without a read");

   a_irq_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !req_valid |-> !irq_to_core)
      else $error("core request shown with no winner");

   a_irq_enabled: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (req_valid && !global_mask_disable_r) |-> irq_to_core)
      else $error("winner held back while enabled");

endmodule : interrupt_vector_status_control

// ### core/intc_vsc_pkg.sv
// constants for the interrupt vector, status and control block
// assumes a 16-bit word bus with word offsets from the module base
// ****************************************************************
// What this block does
// - Control/status bit 15 reads 1 while a request is being sent to the core, else 0.
// - Bits 14:13 report the least level a new request needs to nest, updated on ISR entry.
// - Nesting code 00 lets levels 0-3 nest, 01 levels 1-3, 10 levels 2-3, 11 only level 3.
// - Bits 12:6 hold vector address bits 6:0 of the last request taken, updated on ISR entry.
// - Bit 5 set to 1 suppresses every maskable request to the core; 0 is normal operation.
// - Bits 4..0 enable the debug rx-full, tx-empty, trace, breakpoint-0, step-counter sources.
// - The stored 14-bit vector base drives the upper bits of the 21-bit vector address.
// - The low seven vector address bits come from the winning request, appended under the base.
// - The vector base reset value is a build parameter, 0x0000 or 0x0010 for the small part.
// - Every register returns to its default value on any reset.
// ****************************************************************
package intc_vsc_pkg;
   // register word offsets
   localparam logic [2:0] OFS_CTRL_STATUS = 3'h0;
   localparam logic [2:0] OFS_VECTOR_BASE = 3'h1;
   // control/status field positions
   localparam int BIT_IRQ_ACTIVE = 15;
   localparam int NEST_HI = 14;
   localparam int NEST_LO = 13;
   localparam int LASTVEC_HI = 12;
   localparam int LASTVEC_LO = 6;
   localparam int BIT_GLOBAL_DIS = 5;
   localparam int DBG_EN_HI = 4;
   localparam int DBG_EN_LO = 0;
   // vector base layout
   localparam int BASE_W = 14;
   localparam int LOWVEC_W = 7;
   localparam int VADDR_W = 21;
   // reset values
   localparam logic [15:0] VBA_RST_FULL = 16'h0000;
   localparam logic [15:0] VBA_RST_SMALL = 16'h0010;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic [1:0] NEST_RST = 2'h0;
   localparam logic [6:0] LASTVEC_RST = 7'h00;
   // nesting threshold codes
   typedef enum logic [1:0] {
      NEST_ANY = 2'b00,
      NEST_L1_UP = 2'b01,
      NEST_L2_UP = 2'b10,
      NEST_L3_ONLY = 2'b11
   } nest_code_t;
endpackage : intc_vsc_pkg

// ### dv/core_model.sv
// core side model: answers go with one-cycle service-entry pulses, every other cycle while go and irq_to_core stay high
// assumes go is raised only after the request inputs are settled
module core_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // controller and bench side
   input wire logic irq_to_core,
   input wire logic go,
   output logic core_isr_entry
);
   timeunit 1ns;
   timeprecision 1ns;
   // jump into a routine only while a request is shown, one cycle wide
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         core_isr_entry <= 1'b0;
      end else begin
         core_isr_entry <= go & irq_to_core & ~core_isr_entry;
      end
   end
endmodule : core_model

// ### dv/testbench.sv
// self-checking bench for the vector, status and control block
// assumes the core model stands on the core side of the block
module testbench;
   import intc_vsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // ********
   // stimulus and instances
   // ********
   localparam logic [15:0] VBA_SEL = VBA_RST_SMALL;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ce = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata, rv;
   logic req_valid = 1'b0;
   logic req_maskable = 1'b0;
   logic [1:0] req_level = 2'h0;
   logic [6:0] req_vector_low = 7'h00;
   logic [4:0] dbg_irq_src = 5'h00;
   logic [4:0] dbg_irq_req;
   logic [20:0] vector_addr;
   logic core_isr_entry, irq_to_core;
   logic go = 1'b0;
   int n_fail = 0;
   int n_checks = 0;
   always #25 sys_clk = ~sys_clk;
   interrupt_vector_status_control #(.VBA_RESET(VBA_SEL)) u_interrupt_vector_status_control (
      .sys_clk, .sys_rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .req_valid, .req_maskable, .req_level, .req_vector_low, .core_isr_entry,
      .irq_to_core, .vector_addr, .dbg_irq_src, .dbg_irq_req);
   core_model u_core_model (.sys_clk, .sys_rst, .irq_to_core, .go, .core_isr_entry);
   // ********
   // shared tasks
   // ********
   task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done;
      if (n_fail == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // ********
   // scenarios
   // ********
   // reset defaults back
   task automatic t_reset;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      sys_rst <= 1'b1;
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(OFS_CTRL_STATUS, rv);
      chk(rv, 16'h0000);
      rd(OFS_VECTOR_BASE, rv);
      chk(rv, VBA_SEL);
      chk(vector_addr, {VBA_SEL[13:0], req_vector_low});
   endtask : t_reset
   task automatic t_regs;
      wr(OFS_VECTOR_BASE, 16'hFFFF);
      req_vector_low <= 7'h55;
      rd(OFS_VECTOR_BASE, rv);
      chk(rv, 16'h3FFF);
      chk(vector_addr, {14'h3FFF, 7'h55});
      wr(OFS_CTRL_STATUS, 16'hFFFF);
      wr(3'h5, 16'hFFFF);
      rd(3'h5, rv);
      chk(rv, 16'h0000);
      rd(OFS_CTRL_STATUS, rv);
      chk(rv, 16'h003F);
   endtask : t_regs
   task automatic t_mask;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_maskable <= 1'b1;
      @(negedge sys_clk);
      chk(irq_to_core, 1'b0);
      @(posedge sys_clk);
      req_maskable <= 1'b0;
      @(negedge sys_clk);
      chk(irq_to_core, 1'b1);
      rd(OFS_CTRL_STATUS, rv);
      chk(rv[15], 1'b1);
      wr(OFS_CTRL_STATUS, 16'h0000);
      req_maskable <= 1'b1;
      @(negedge sys_clk);
      chk(irq_to_core, 1'b1);
   endtask : t_mask
   task automatic t_debug;
      @(posedge sys_clk);
      dbg_irq_src <= 5'h1F;
      for (int i = 0; i < 5; i++) begin
         wr(OFS_CTRL_STATUS, 16'h0001 << i);
         @(posedge sys_clk);
         #1 chk(dbg_irq_req, 5'h01 << i);
      end
   endtask : t_debug
   task automatic t_nest;
      int k;
      for (int l = 0; l < 4; l++) begin
         @(posedge sys_clk);
         req_level <= 2'(l);
         req_vector_low <= 7'h11 + 7'(l);
         go <= 1'b1;
         k = 0;
         while (core_isr_entry !== 1'b1 && k < 20) begin
            @(negedge sys_clk);
            k++;
         end
         if (core_isr_entry !== 1'b1) begin
            chk(core_isr_entry, 1'b1);
            test_done;
         end
         @(posedge sys_clk);
         go <= 1'b0;
         rd(OFS_CTRL_STATUS, rv);
         chk(rv[14:13], (l == 3) ? 2'b11 : 2'(l + 1));
         chk(rv[12:6], 7'h11 + 7'(l));
      end
   endtask : t_nest
   // clock enable low freezes all state
   task automatic t_freeze;
      @(posedge sys_clk);
      ce <= 1'b0;
      reg_addr <= OFS_VECTOR_BASE;
      reg_wdata <= 16'h1234;
      reg_wr <= 1'b1;
      req_vector_low <= 7'h7F;
      dbg_irq_src <= 5'h00;
      repeat (2) @(posedge sys_clk);
      reg_wr <= 1'b0;
      ce <= 1'b1;
      @(negedge sys_clk);
      chk(vector_addr, {14'h3FFF, 7'h14});
      chk(dbg_irq_req, 5'h10);
      rd(OFS_VECTOR_BASE, rv);
      chk(rv, 16'h3FFF);
      chk(vector_addr, {14'h3FFF, 7'h7F});
      chk(dbg_irq_req, 5'h00);
   endtask : t_freeze
   initial begin
      t_reset;
      t_regs;
      t_mask;
      t_debug;
      t_nest;
      t_freeze;
      t_reset;
      test_done;
   end
endmodule : testbench
